// *** src/compact_timer.sv ***
// Compact 10-bit timer: registers, counter, comparators and output pin logic
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"
module compact_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire compact_timer_pkg::reg_addr_t i_addr,
  input wire compact_timer_pkg::reg_data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_time_base_tick,
  input wire logic i_external_count_pin,
  output compact_timer_pkg::reg_data_t o_rdata,
  output logic o_timer_output_pin,
  output logic o_timer_output_en,
  output logic o_compare_a_flag,
  output logic o_period_match_flag
);
  import compact_timer_pkg::*;

  // ==========================================
  // State
  logic [7:0] ctrl0, next_ctrl0;
  logic [7:0] ctrl1, next_ctrl1;
  logic [9:0] count, next_count;
  logic [9:0] compare_a, next_compare_a;
  logic run_d, pin_level, next_pin_level;
  reg_data_t next_rdata;
  logic next_pin, next_en, next_aflag, next_pflag;
  logic tick;

  // ==========================================
  // Decoded fields
  logic run, pause, clr_src, swap, out_ctrl, invert;
  logic [2:0] period_field;
  logic [1:0] out_fn;
  mode_t mode;
  clk_sel_t clk_sel;
  logic run_rise, advance, pwm, clear_on_a;
  logic [9:0] inc, duty;
  logic p_hit, a_hit, p_event, a_event, pwm_active;

  assign run = ctrl0[`POS_RUN];
  assign pause = ctrl0[`POS_PAUSE];
  assign period_field = ctrl0[`POS_PERIOD_HI:`POS_PERIOD_LO];
  assign clk_sel = clk_sel_t'(ctrl0[`POS_CLK_SEL_HI:`POS_CLK_SEL_LO]);
  assign mode = mode_t'(ctrl1[`POS_MODE_HI:`POS_MODE_LO]); // see (RL10)
  assign out_fn = ctrl1[`POS_OUT_FN_HI:`POS_OUT_FN_LO];
  assign out_ctrl = ctrl1[`POS_OUT_CTRL];
  assign invert = ctrl1[`POS_INVERT];
  assign swap = ctrl1[`POS_SWAP];
  assign clr_src = ctrl1[`POS_CLR_SRC];

  tick_source u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_select(clk_sel),
    .i_time_base_tick(i_time_base_tick),
    .i_external_count_pin(i_external_count_pin),
    .o_tick(tick)
  );

  // ==========================================
  // Counter and comparators
  always_comb begin
    run_rise = run & ~run_d;
    // Run rise wins over a tick so the restart always begins at zero
    advance = tick & run & ~pause & ~run_rise; // see (RL4) see (RL6)
    inc = count + 10'h001; // see (RL1)
    p_hit = (period_field != 3'h0) ? (inc == {period_field, `PERIOD_SHIFT_ZEROS}) // see (RL2)
                                   : (count == `COUNT_MAX); // see (RL8)
    a_hit = (compare_a != `RST_COMPARE_A) && (inc == compare_a); // see (RL2)
    pwm = mode == MODE_PWM;
    clear_on_a = pwm ? swap : clr_src; // see (RL17) see (RL21)
    p_event = advance & p_hit & ~(~pwm & clr_src); // see (RL20) see (RL22)
    a_event = advance & a_hit; // see (RL22)
    next_count = count;
    if (run_rise) begin
      next_count = `RST_COUNT; // see (RL3)
    end else if (advance) begin
      // With clear on compare A, overflow wraps to zero through the adder itself
      next_count = (clear_on_a ? a_hit : p_hit) ? `RST_COUNT : inc; // see (RL9) see (RL3)
    end
    next_aflag = a_event; // see (RL15)
    next_pflag = p_event; // see (RL15)
  end

  // ==========================================
  // Output pin
  always_comb begin
    next_pin_level = pin_level;
    if (run_rise && mode == MODE_COMPARE) begin
      next_pin_level = out_ctrl; // see (RL7) see (RL18)
    end else if (a_event && mode == MODE_COMPARE) begin
      unique case (out_fn) // see (RL13) see (RL20)
        2'h0: next_pin_level = pin_level;
        2'h1: next_pin_level = 1'b0;
        2'h2: next_pin_level = 1'b1;
        2'h3: next_pin_level = ~pin_level;
      endcase
    end
    duty = swap ? {period_field, `PERIOD_SHIFT_ZEROS} : compare_a; // see (RL21)
    // Duty at or past the period keeps the waveform fully active
    pwm_active = count < duty;
    unique case (mode)
      MODE_COMPARE: next_pin = next_pin_level ^ invert; // see (RL19)
      MODE_PWM: begin
        unique case (out_fn) // see (RL14)
          2'h1: next_pin = out_ctrl ^ invert;
          2'h2: next_pin = (pwm_active ? out_ctrl : ~out_ctrl) ^ invert; // see (RL18)
          default: next_pin = ~out_ctrl ^ invert;
        endcase
      end
      default: next_pin = 1'b0;
    endcase
    next_en = (mode == MODE_COMPARE) || pwm; // see (RL12)
  end

  // ==========================================
  // Register port
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_compare_a = compare_a;
    next_rdata = 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        `OFS_CONTROL_ZERO: next_ctrl0 = i_wdata;
        `OFS_CONTROL_ONE: next_ctrl1 = i_wdata;
        `OFS_COMPARE_A_LOW: next_compare_a[7:0] = i_wdata; // see (RL16)
        `OFS_COMPARE_A_HIGH: next_compare_a[9:8] = i_wdata[1:0];
        default: next_ctrl0 = ctrl0;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        `OFS_CONTROL_ZERO: next_rdata = ctrl0;
        `OFS_CONTROL_ONE: next_rdata = ctrl1;
        `OFS_COUNTER_LOW: next_rdata = count[7:0]; // see (RL16)
        `OFS_COUNTER_HIGH: next_rdata = {6'h00, count[9:8]};
        `OFS_COMPARE_A_LOW: next_rdata = compare_a[7:0];
        `OFS_COMPARE_A_HIGH: next_rdata = {6'h00, compare_a[9:8]};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl0 <= `RST_CONTROL;
      ctrl1 <= `RST_CONTROL;
      compare_a <= `RST_COMPARE_A;
      count <= `RST_COUNT;
      run_d <= 1'b0;
      pin_level <= 1'b0;
      o_rdata <= 8'h00;
      o_timer_output_pin <= 1'b0;
      o_timer_output_en <= 1'b0;
      o_compare_a_flag <= 1'b0;
      o_period_match_flag <= 1'b0;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      compare_a <= next_compare_a;
      count <= next_count;
      run_d <= run;
      pin_level <= next_pin_level;
      o_rdata <= next_rdata;
      o_timer_output_pin <= next_pin;
      o_timer_output_en <= next_en;
      o_compare_a_flag <= next_aflag;
      o_period_match_flag <= next_pflag;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  count_step_a: assert property ( // see (RL1)
    advance && !(clear_on_a ? a_hit : p_hit) |=> count == $past(count) + 10'h001)
    else $error("counter did not step by one");
  run_rise_zero_a: assert property ( // see (RL6)
    $rose(run) |=> count == 10'h000 ##1 $stable(count) || $past(advance))
    else $error("run rise did not zero the counter");
  pause_hold_a: assert property ( // see (RL4)
    pause && run_d && run |=> count == $past(count))
    else $error("counter moved while paused");
  stop_hold_a: assert property ( // see (RL6)
    !run [*2] |=> $stable(count))
    else $error("counter moved while stopped");
  period_clear_a: assert property ( // see (RL8)
    advance && !pwm && !clr_src && period_field != 3'h0 && inc == {period_field, 7'h00}
    |=> count == 10'h000 && o_period_match_flag)
    else $error("period match did not clear counter");
  overflow_flag_a: assert property ( // see (RL9)
    advance && !clr_src && period_field == 3'h0 && count == 10'h3ff
    |=> count == 10'h000 && o_period_match_flag)
    else $error("overflow did not clear and flag");
  no_pflag_a: assert property ( // see (RL20)
    o_period_match_flag |-> $past(!clr_src || pwm))
    else $error("period flag raised with clear on compare A");
  a_clear_a: assert property ( // see (RL17)
    advance && !pwm && clr_src && a_hit |=> count == 10'h000 && o_compare_a_flag)
    else $error("compare A match did not clear counter");
  pin_init_a: assert property ( // see (RL7)
    $rose(run) && mode == MODE_COMPARE |=> o_timer_output_pin == $past(out_ctrl ^ invert))
    else $error("pin not restored on run rise");
  timer_no_drive_a: assert property ( // see (RL12)
    mode == MODE_TIMER |=> !o_timer_output_en)
    else $error("pin driven in timer mode");
  pwm_force_a: assert property ( // see (RL14)
    pwm && out_fn == 2'h1 |=> o_timer_output_pin == $past(out_ctrl ^ invert))
    else $error("forced active level wrong");


  // ==========================================
  // Register port, counter, flags and pin checks
  rdata_idle_a: assert property ( // see (RL16)
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  count_low_rd_a: assert property ( // see (RL16)
    i_rd && i_addr == `OFS_COUNTER_LOW |=> o_rdata == $past(count[7:0]))
    else $error("counter low byte read wrong");
  count_high_rd_a: assert property ( // see (RL16)
    i_rd && i_addr == `OFS_COUNTER_HIGH |=> o_rdata == {6'h00, $past(count[9:8])})
    else $error("counter high byte read wrong");
  cmp_low_wr_a: assert property ( // see (RL16)
    i_wr && i_addr == `OFS_COMPARE_A_LOW |=> compare_a[7:0] == $past(i_wdata))
    else $error("compare A low byte not written");
  cmp_high_wr_a: assert property ( // see (RL16)
    i_wr && i_addr == `OFS_COMPARE_A_HIGH |=> compare_a[9:8] == $past(i_wdata[1:0]))
    else $error("compare A high bits not written");
  count_ro_a: assert property ( // see (RL3)
    i_wr && (i_addr == `OFS_COUNTER_LOW || i_addr == `OFS_COUNTER_HIGH) && !advance
    && !run_rise |=> $stable(count))
    else $error("software write changed the counter");
  no_tick_hold_a: assert property ( // see (RL1)
    !tick && !run_rise |=> $stable(count))
    else $error("counter moved without a tick");
  a_flag_cause_a: assert property ( // see (RL22)
    o_compare_a_flag |-> $past(advance))
    else $error("compare A flag without a counted tick");
  p_flag_cause_a: assert property ( // see (RL22)
    o_period_match_flag |-> $past(advance))
    else $error("period flag without a counted tick");
  p_flag_zero_a: assert property ( // see (RL9)
    o_period_match_flag && $past(!clear_on_a) |-> count == 10'h000)
    else $error("period flag without counter clear");
  a_flag_zero_a: assert property ( // see (RL17)
    o_compare_a_flag && $past(clear_on_a) |-> count == 10'h000)
    else $error("compare A flag without counter clear");
  no_a_zero_a: assert property ( // see (RL2)
    compare_a == 10'h000 |=> !o_compare_a_flag)
    else $error("compare A flag with zero compare value");
  pin_steady_a: assert property ( // see (RL20)
    !(mode == MODE_COMPARE && (a_event || run_rise)) |=> $stable(pin_level))
    else $error("pin level changed without A match or run rise");
  pin_low_a: assert property ( // see (RL13)
    a_event && mode == MODE_COMPARE && out_fn == 2'h1 |=> !pin_level)
    else $error("pin not driven low on A match");
  pin_high_a: assert property ( // see (RL13)
    a_event && mode == MODE_COMPARE && out_fn == 2'h2 |=> pin_level)
    else $error("pin not driven high on A match");
  pin_toggle_a: assert property ( // see (RL13)
    a_event && mode == MODE_COMPARE && out_fn == 2'h3 |=> pin_level != $past(pin_level))
    else $error("pin not toggled on A match");
  pin_invert_a: assert property ( // see (RL19)
    mode == MODE_COMPARE |=> o_timer_output_pin == (pin_level ^ $past(invert)))
    else $error("compare pin polarity wrong");
  pwm_inactive_a: assert property ( // see (RL14)
    pwm && out_fn == 2'h0 |=> o_timer_output_pin == $past(~out_ctrl ^ invert))
    else $error("forced inactive level wrong");
  pwm_start_a: assert property ( // see (RL18)
    pwm && out_fn == 2'h2 && count == 10'h000 && duty != 10'h000
    |=> o_timer_output_pin == $past(out_ctrl ^ invert))
    else $error("waveform not active at period start");
  timer_pin_low_a: assert property ( // see (RL19)
    mode == MODE_TIMER |=> !o_timer_output_pin)
    else $error("pin level set in timer mode");
  cmp_drive_a: assert property ( // see (RL10)
    mode == MODE_COMPARE || pwm |=> o_timer_output_en)
    else $error("pin not driven in compare or PWM mode");
  undef_no_drive_a: assert property ( // see (RL10)
    mode == MODE_UNDEF |=> !o_timer_output_en)
    else $error("pin driven in undefined mode");
  pwm_swap_clear_a: assert property ( // see (RL21)
    advance && pwm && swap && a_hit |=> count == 10'h000)
    else $error("swapped PWM period not cleared by compare A");
  pwm_period_clear_a: assert property ( // see (RL21)
    advance && pwm && !swap && p_hit |=> count == 10'h000)
    else $error("PWM period not cleared by period match");
  pause_flag_a: assert property ( // see (RL4)
    pause |=> !o_compare_a_flag && !o_period_match_flag)
    else $error("flag raised while paused");
  stop_flag_a: assert property ( // see (RL6)
    !run |=> !o_compare_a_flag && !o_period_match_flag)
    else $error("flag raised while stopped");

  period_seen_c: cover property (o_period_match_flag);
  a_match_seen_c: cover property (o_compare_a_flag && mode == MODE_COMPARE);
  pwm_wave_c: cover property (pwm && out_fn == 2'h2 ##1 $changed(o_timer_output_pin));
  pause_seen_c: cover property (run && pause ##1 run && !pause);
  timer_count_c: cover property (mode == MODE_TIMER && advance);
endmodule : compact_timer

// *** src/compact_timer_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the compact timer
// Notes on behaviour
// (RL1) Ten-bit counter counts up per selected tick
// (RL2) Period field vs bits 9..7; compare A all
// (RL3) Software clears only via run rise; hardware auto-clears
// (RL4) Pause freezes counter; resume from held value
// (RL5) Clock select picks one of seven tick sources by eight codes; SEL_TBC_A and SEL_TBC_B share one
// (RL6) Run rise zeroes and starts; fall stops, keeps
// (RL7) Run rise restores pin initial level, compare mode
// (RL8) Period match every field x 128; zero overflows
// (RL9) Clear source 0: period match or overflow clears
// (RL10) Two-bit mode field: compare, PWM, timer
// (RL11) Software stops timer before changing mode
// (RL12) Timer mode: pin function left disabled
// (RL13) Compare mode: A match keeps, lows, highs, toggles
// (RL14) PWM: inactive, active, waveform; 11 undefined
// (RL15) Automatic clear raises timer interrupt request
// (RL16) Counter pair read-only; compare A pair read/write
// (RL17) Clear source 1: compare A match clears; PWM ignores
// (RL18) Output control: initial level or PWM active level
// (RL19) Invert bit flips pin; ignored in timer mode
// (RL20) Clear on A: no period flag, pin on A only
// (RL21) Swap bit exchanges PWM period and duty comparators
// (RL22) One match pulse per event, system-clock aligned
`ifndef COMPACT_TIMER_CFG_SVH
`define COMPACT_TIMER_CFG_SVH

// ==========================================
// Register offsets
`define OFS_CONTROL_ZERO 3'h0
`define OFS_CONTROL_ONE 3'h1
`define OFS_COUNTER_LOW 3'h2
`define OFS_COUNTER_HIGH 3'h3
`define OFS_COMPARE_A_LOW 3'h4
`define OFS_COMPARE_A_HIGH 3'h5

// ==========================================
// Field positions, control zero
`define POS_PAUSE 7
`define POS_CLK_SEL_HI 6
`define POS_CLK_SEL_LO 4
`define POS_RUN 3
`define POS_PERIOD_HI 2
`define POS_PERIOD_LO 0

// ==========================================
// Field positions, control one
`define POS_MODE_HI 7
`define POS_MODE_LO 6
`define POS_OUT_FN_HI 5
`define POS_OUT_FN_LO 4
`define POS_OUT_CTRL 3
`define POS_INVERT 2
`define POS_SWAP 1
`define POS_CLR_SRC 0

// ==========================================
// Reset values and counts
`define RST_CONTROL 8'h00
`define RST_COUNT 10'h000
`define RST_COMPARE_A 10'h000
`define COUNT_MAX 10'h3ff
`define PERIOD_SHIFT_ZEROS 7'h00
`define DIV_SYS_MASK 6'h03
`define DIV_16_MASK 6'h0f
`define DIV_64_MASK 6'h3f

`endif

// *** src/compact_timer_pkg.sv ***
// Types shared by the compact timer modules
package compact_timer_pkg;
  typedef logic [2:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0, MODE_UNDEF = 2'h1, MODE_PWM = 2'h2, MODE_TIMER = 2'h3
  } mode_t;
  typedef enum logic [2:0] {
    SEL_SYS_DIV4 = 3'h0, SEL_HIGH = 3'h1, SEL_HIGH_DIV16 = 3'h2, SEL_HIGH_DIV64 = 3'h3,
    SEL_TBC_A = 3'h4, SEL_TBC_B = 3'h5, SEL_PIN_RISE = 3'h6, SEL_PIN_FALL = 3'h7
  } clk_sel_t;
endpackage : compact_timer_pkg

// *** src/tick_source.sv ***
// Counter tick selector: prescaler, time-base enable and synchronised count pin
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"
module tick_source (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire compact_timer_pkg::clk_sel_t i_select,
  input wire logic i_time_base_tick,
  input wire logic i_external_count_pin,
  output logic o_tick
);
  import compact_timer_pkg::*;

  // ==========================================
  // Prescaler and pin synchroniser
  logic [5:0] prescale, next_prescale;
  logic pin_meta, pin_sync, pin_prev;
  logic next_tick;

  // High-speed clock is taken as the block clock itself
  always_comb begin
    next_prescale = prescale + 6'h01;
    unique case (i_select) // see (RL5)
      SEL_SYS_DIV4: next_tick = (prescale & `DIV_SYS_MASK) == `DIV_SYS_MASK;
      SEL_HIGH: next_tick = 1'b1;
      SEL_HIGH_DIV16: next_tick = (prescale & `DIV_16_MASK) == `DIV_16_MASK;
      SEL_HIGH_DIV64: next_tick = prescale == `DIV_64_MASK;
      SEL_TBC_A, SEL_TBC_B: next_tick = i_time_base_tick;
      SEL_PIN_RISE: next_tick = pin_sync & ~pin_prev;
      SEL_PIN_FALL: next_tick = ~pin_sync & pin_prev;
    endcase
  end

  // Only pin_sync reads the first stage, keeping metastability contained
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale <= 6'h00;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      prescale <= next_prescale;
      pin_meta <= i_external_count_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      o_tick <= next_tick;
    end
  end
endmodule : tick_source

// *** verification/count_pin_model.sv ***
// Far-side model that drives the external count pin
`timescale 1ns/100ps
module count_pin_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_pulses,
  output logic o_pin
);
  logic [4:0] left;
  logic [3:0] gap;
  initial begin
    o_pin = 1'b0;
    left = 5'h00;
    gap = 4'h0;
  end
  // Eight clocks per level, slow enough for the two-flop synchroniser
  always @(posedge i_clk) begin
    gap <= gap + 4'h1;
    if (i_go) begin
      left <= {i_pulses, 1'b0};
      gap <= 4'h0;
    end else if (left != 5'h00 && gap == 4'h7) begin
      o_pin <= ~o_pin;
      left <= left - 5'h01;
      gap <= 4'h0;
    end
  end
endmodule : count_pin_model

// *** verification/tb_top.sv ***
// Self-checking bench for the compact timer
`timescale 1ns/100ps
module tb_top;
  import compact_timer_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, i_time_base_tick, ext_pin, go;
  logic o_timer_output_pin, o_timer_output_en, o_compare_a_flag, o_period_match_flag;
  reg_addr_t i_addr;
  reg_data_t i_wdata, o_rdata, d, r;
  logic [9:0] c1, c2;
  int error_cnt, checks, cyc, seed, n, s, f;
  logic [7:0] pk1 [6] = '{8'ha8, 8'hac, 8'haa, 8'h88, 8'h98, 8'h94};
  logic [7:0] pk0 [6] = '{8'h1a, 8'h1a, 8'h19, 8'h1a, 8'h1a, 8'h1a};
  logic [9:0] pa [6] = '{10'h040, 10'h040, 10'h100, 10'h040, 10'h040, 10'h040};
  int pe [6] = '{64, 192, 128, 0, 256, 256};
  compact_timer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_time_base_tick(i_time_base_tick),
    .i_external_count_pin(ext_pin), .o_rdata(o_rdata), .o_timer_output_pin(o_timer_output_pin),
    .o_timer_output_en(o_timer_output_en), .o_compare_a_flag(o_compare_a_flag),
    .o_period_match_flag(o_period_match_flag));
  count_pin_model pin_u (.i_clk(i_clk), .i_go(go), .i_pulses(4'h5), .o_pin(ext_pin));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========
  // Helpers
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input reg_addr_t a, input reg_data_t v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input reg_addr_t a, output reg_data_t v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask : rd
  // Only meaningful while the counter is stopped or paused
  task rdc(output logic [9:0] v);
    rd(3'h2, d);
    rd(3'h3, r);
    v = {r[1:0], d};
  endtask : rdc
  task wa(input logic [9:0] v);
    wr(3'h4, v[7:0]);
    wr(3'h5, {6'h00, v[9:8]});
  endtask : wa
  task start(input reg_data_t k1, input reg_data_t k0);
    wr(3'h0, k0 & 8'hf7);
    wr(3'h1, k1);
    wr(3'h0, k0);
  endtask : start
  function automatic logic sig(input int w);
    return (w == 0) ? o_period_match_flag : (w == 1) ? o_compare_a_flag : o_timer_output_pin;
  endfunction : sig
  task wf(input int w);
    repeat (2100) if (sig(w) !== 1'b1) @(negedge i_clk);
  endtask : wf
  task gap(input int w, output int m);
    wf(w);
    m = 0;
    do begin
      @(negedge i_clk);
      m++;
    end while (sig(w) !== 1'b1 && m < 2100);
  endtask : gap
  task hi(input int w, input int cy, output int m);
    m = 0;
    repeat (cy) begin
      @(negedge i_clk);
      if (sig(w) === 1'b1) m++;
    end
  endtask : hi
  function automatic int exp_cnt(input int k);
    case (k)
      0: return 64;
      1: return 256;
      2: return 16;
      3: return 4;
      4, 5: return 8;
      default: return 5;
    endcase
  endfunction : exp_cnt
  function automatic logic pin_after(input int fn, input logic oc);
    case (fn)
      0: return oc;
      1: return 1'b0;
      2: return 1'b1;
      default: return ~oc;
    endcase
  endfunction : pin_after
  // ==========
  // Main sequence
  initial begin
    seed = 86402;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_time_base_tick = 1'b0;
    go = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (s = 0; s < 8; s++) begin
      rd(s[2:0], d);
      chk(d, 0);
    end
    repeat (4) begin
      r = 8'($random(seed));
      c1[7:0] = r;
      wr(3'h4, r);
      wr(3'h5, r);
      wr(3'h2, r);
      wr(3'h1, r);
      rd(3'h4, d);
      chk(d, c1[7:0]);
      rd(3'h5, d);
      chk(d, c1[7:0] & 8'h03);
      rd(3'h2, d);
      chk(d, 0);
      rd(3'h1, d);
      chk(d, c1[7:0]);
    end
    $display("register test done");
    wa(10'h000);
    for (s = 0; s < 4; s++) begin
      f = (s == 0) ? 0 : (s == 1) ? 1 : (s == 2) ? 7 : 1 + ($unsigned($random(seed)) % 7);
      start((s == 3) ? 8'hc0 : 8'h00, 8'h18 | f[7:0]);
      chk(o_timer_output_en, s != 3);
      gap(0, n);
      chk(n, (f == 0) ? 1024 : f * 128);
    end
    $display("period test done");
    wa(10'd200);
    start(8'h01, 8'h19);
    gap(1, n);
    chk(n, 200);
    hi(0, 400, n);
    chk(n, 0);
    $display("clear source test done");
    wa(10'd50);
    for (s = 0; s < 8; s++) begin
      f = s >> 1;
      r = 8'($random(seed));
      start({2'b00, f[1:0], r[3], s[0], 2'b01}, 8'h18);
      repeat (3) @(negedge i_clk);
      chk(o_timer_output_pin, r[3] ^ s[0]);
      wf(1);
      repeat (3) @(negedge i_clk);
      chk(o_timer_output_pin, pin_after(f, r[3]) ^ s[0]);
    end
    $display("compare output test done");
    for (s = 0; s < 6; s++) begin
      wa(pa[s]);
      start(pk1[s], pk0[s]);
      repeat (300) @(negedge i_clk);
      hi(2, 256, n);
      chk(n, pe[s]);
    end
    $display("pwm test done");
    start(8'hc0, 8'h18);
    repeat (50) @(negedge i_clk);
    wr(3'h0, 8'h98);
    rdc(c1);
    repeat (20) @(negedge i_clk);
    rdc(c2);
    chk(c2, c1);
    wr(3'h0, 8'h18);
    repeat (20) @(negedge i_clk);
    wr(3'h0, 8'h10);
    rdc(c2);
    chk(c2 > c1 && c2 < c1 + 40, 1);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    rdc(c1);
    chk(c1, c2);
    wr(3'h0, 8'h18);
    rdc(c2);
    chk(c2 < 10, 1);
    $display("pause and run test done");
    for (s = 0; s < 8; s++) begin
      start(8'hc0, {1'b0, s[2:0], 4'h8});
      for (f = 0; f < 256; f++) begin
        @(posedge i_clk);
        i_time_base_tick <= (f % 32 == 5);
        go <= (f == 0);
      end
      wr(3'h0, {1'b0, s[2:0], 4'h0});
      rdc(c1);
      chk(c1 + 3 >= exp_cnt(s) && c1 <= exp_cnt(s) + 3, 1);
    end
    $display("clock select test done");
    end_of_test();
  end
endmodule : tb_top
